/* File: verification/dspr_core_regs_assertions.sv */
`timescale 1ns/1ns
module dspr_core_regs_chk (
	input wire logic clock,
	input wire logic rst,
	input wire logic [dspr_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire dspr_pkg::dspr_flow_t flow_in,
	input wire logic flow_ready,
	input wire logic flow_done,
	input wire logic [dspr_pkg::PC_W-1:0] prog_addr,
	input wire dspr_pkg::dspr_mreq_t dw_bus,
	input wire logic dw_ready,
	input wire logic dr_valid,
	input wire logic [dspr_pkg::PAGE128_OFF_W-1:0] dir_off,
	input wire logic [31:0] dir_addr,
	input wire logic [dspr_pkg::IRQ_N-1:0] irq_in,
	input wire dspr_pkg::dspr_irq_t int_ack,
	input wire dspr_pkg::dspr_irq_t int_out
);
	import dspr_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	logic acc;
	logic rd_ok;
	// Accepted flow request and accepted bus read
	assign acc = flow_ready && flow_in.op != FLOW_NONE;
	assign rd_ok = avs_read && !avs_waitrequest;
	property p_rpc_lat;
		acc && flow_in.op == FLOW_RET_RPC ##2 dr_valid |-> ##2 flow_done;
	endproperty
	a_rpc_lat: assert property (p_rpc_lat) else $error("fast return late");
	property p_ret_lat;
		acc && flow_in.op == FLOW_RET ##2 dr_valid |-> ##6 flow_done;
	endproperty
	a_ret_lat: assert property (p_ret_lat) else $error("stack return late");
	property p_ret_early;
		acc && flow_in.op == FLOW_RET |=> !flow_done [*7];
	endproperty
	a_ret_early: assert property (p_ret_early) else $error("stack return early");
	property p_pc_load;
		acc && flow_in.op inside {FLOW_JUMP, FLOW_CALL, FLOW_CALL_RPC}
			|=> prog_addr == $past(flow_in.target);
	endproperty
	a_pc_load: assert property (p_pc_load) else $error("pc not loaded");
	property p_push;
		acc && flow_in.op == FLOW_CALL |=> dw_bus.req && dw_bus.data[21:0] == $past(flow_in.ret);
	endproperty
	a_push: assert property (p_push) else $error("call push wrong");
	property p_hold;
		dw_bus.req && !dw_ready |=> dw_bus.req && $stable(dw_bus.addr) && $stable(dw_bus.data);
	endproperty
	a_hold: assert property (p_hold) else $error("push dropped");
	property p_dir;
		1'h1 |=> dir_addr[5:0] == $past(dir_off[5:0]);
	endproperty
	a_dir: assert property (p_dir) else $error("direct offset wrong");
	property p_ack;
		(int_ack.valid && irq_in == '0) ##1 irq_in == '0
			|=> !(int_out.valid && int_out.num == $past(int_ack.num, 2));
	endproperty
	a_ack: assert property (p_ack) else $error("acked line still out");
	property p_pc_rd;
		rd_ok && avs_address == 8'h34 && $stable(prog_addr) |-> avs_readdata == {10'h0, prog_addr};
	endproperty
	a_pc_rd: assert property (p_pc_rd) else $error("pc readback wrong");
	property p_dp_rd;
		rd_ok && avs_address == 8'h30 |-> avs_readdata[31:16] == 16'h0;
	endproperty
	a_dp_rd: assert property (p_dp_rd) else $error("page pointer too wide");
endmodule : dspr_core_regs_chk
bind dspr_core_regs dspr_core_regs_chk u_chk (.clock, .rst, .avs_address, .avs_read,
	.avs_readdata, .avs_waitrequest, .flow_in, .flow_ready, .flow_done, .prog_addr, .dw_bus,
	.dw_ready, .dr_valid, .dir_off, .dir_addr, .irq_in, .int_ack, .int_out);

/* File: verification/dspr_cpu_register_set_tb_top.sv */
`timescale 1ns/1ns
module dspr_cpu_register_set_tb_top;
	import dspr_pkg::*;
	typedef struct packed {logic [7:0] a; logic [3:0] be; logic [31:0] d, x;} dspr_row_t;
	typedef struct packed {
		dspr_flow_op_t op;
		logic [21:0] t, r;
		logic [3:0] s, n;
		logic [21:0] pc, return_address_reg;
		logic [15:0] sp;
	} dspr_fr_t;
	logic clock = '0, rst = 1'h1, avs_read = '0, avs_write = '0, dbg_halt = '0;
	logic [7:0] avs_address = '0;
	logic [3:0] avs_byteenable = '0, slow = '0;
	logic [31:0] avs_writedata = '0, avs_readdata, rd, core_rdata, dir_addr, dr_data;
	logic avs_waitrequest, flow_ready, flow_done, dw_ready, dr_valid;
	logic [5:0] core_rd_sel = '0;
	logic [21:0] prog_addr;
	logic [6:0] dir_off = '0;
	logic [15:0] irq_in = '0;
	dspr_wr_t core_wr = '0;
	dspr_flow_t flow_in = '0;
	dspr_mreq_t dw_bus, dr_bus;
	dspr_irq_t int_ack = '0, int_out;
	int failures = 0, n_tests = 0, n;
	dspr_row_t rows [11] = '{
		'{8'h00, 4'hF, 32'h1234_5678, 32'h1234_5678},
		'{8'h00, 4'h3, 32'hFFFF_ABCD, 32'h1234_ABCD},
		'{8'h04, 4'hC, 32'h5A5A_0000, 32'h5A5A_0000},
		'{8'h04, 4'h3, 32'hFFFF_1111, 32'h5A5A_1111},
		'{8'h08, 4'h3, 32'h8765_4321, 32'h0000_4321},
		'{8'h0C, 4'hF, 32'hAAAA_BBBB, 32'hAAAA_BBBB},
		'{8'h28, 4'h3, 32'hFFFF_1111, 32'h0000_1111},
		'{8'h30, 4'hF, 32'hFFFF_00D1, 32'h0000_00D1},
		'{8'h34, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000},
		'{8'h3C, 4'hF, 32'hFFFF_8000, 32'h0000_8000},
		'{8'h80, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000}};
	// Pushes land at 0x400 and 0x402; slow memory on the second call and last return
	dspr_fr_t flows [7] = '{
		'{FLOW_CALL_RPC, 22'h01_2345, 22'hA1, 4'h0, 4'h3, 22'h01_2345, 22'hA1, 16'h0402},
		'{FLOW_CALL_RPC, 22'h00_0777, 22'hB2, 4'h2, 4'h0, 22'h00_0777, 22'hB2, 16'h0404},
		'{FLOW_RET_RPC, 22'h0, 22'h0, 4'h0, 4'h4, 22'hB2, 22'hA1, 16'h0402},
		'{FLOW_RET, 22'h0, 22'h0, 4'h0, 4'h8, 22'h0, 22'hA1, 16'h0400},
		'{FLOW_CALL, 22'h3F_FFFF, 22'h155, 4'h0, 4'h3, 22'h3F_FFFF, 22'hA1, 16'h0402},
		'{FLOW_RET, 22'h0, 22'h0, 4'h6, 4'h0, 22'h155, 22'hA1, 16'h0400},
		'{FLOW_JUMP, 22'h2A_AAAA, 22'h0, 4'h0, 4'h1, 22'h2A_AAAA, 22'hA1, 16'h0400}};
	dspr_core_regs DUT (.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .core_wr, .core_rd_sel, .core_rdata,
		.flow_in, .flow_ready, .flow_done, .prog_addr, .dw_bus, .dw_ready, .dr_bus, .dr_valid,
		.dr_data, .dir_off, .dir_addr, .irq_in, .dbg_halt, .int_ack, .int_out);
	dspr_mem_model u_mem (.clock, .slow, .dw_bus, .dw_ready, .dr_bus, .dr_valid, .dr_data);
	always #4 clock = ~clock;
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	task automatic hung();
		failures++;
		end_of_test();
	endtask : hung
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
			failures++;
		if (g !== e)
			$display("BAD %s expected %h seen %h", s, e, g);
	endtask : chk
	// Request stands until waitrequest is seen low at an edge; gap cycle after
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		int i;
		{avs_write, avs_read, avs_address, avs_writedata, avs_byteenable} <= {w, !w, a, d, be};
		for (i = 0; i < 40; i++) begin
			@(posedge clock);
			if (avs_waitrequest === 1'h0)
				break;
		end
		rd = avs_readdata;
		{avs_write, avs_read} <= 2'h0;
		@(posedge clock);
		if (i == 40)
			hung();
	endtask : bus
	task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0, 4'hF);
		chk(s, e, rd);
	endtask : rdchk
	// Hold the op until taken, then count edges to the done pulse
	task automatic flow(input dspr_fr_t f);
		slow <= f.s;
		flow_in <= '{f.op, f.t, f.r};
		for (n = 0; n < 40; n++) begin
			@(posedge clock);
			if (flow_ready === 1'h1)
				break;
		end
		if (n == 40)
			hung();
		flow_in.op <= FLOW_NONE;
		for (n = 0; n < 40; n++) begin
			@(posedge clock);
			if (flow_done === 1'h1)
				break;
		end
		n++;
		if (n > 40)
			hung();
	endtask : flow
	initial begin
		repeat (6) @(posedge clock);
		rst <= 1'h0;
		foreach (rows[k]) begin
			bus(1'h1, rows[k].a, rows[k].d, rows[k].be);
			rdchk("reg", rows[k].a, rows[k].x);
		end
		core_wr <= '{1'h1, IDX_AUX0, 1'h1, 1'h0, 32'hFFFF_2222};
		@(posedge clock);
		core_wr.valid <= 1'h0;
		core_rd_sel <= IDX_AUX0;
		repeat (2) @(posedge clock);
		chk("core rd", 32'hAAAA_2222, core_rdata);
		dir_off <= 7'h16;
		bus(1'h1, 8'h48, 32'h0, 4'hF);
		chk("dir64", 32'h3456, dir_addr);
		bus(1'h1, 8'h48, 32'h1, 4'hF);
		dir_off <= 7'h56;
		repeat (2) @(posedge clock);
		chk("dir128", 32'h3456, dir_addr);
		foreach (flows[k]) begin
			flow(flows[k]);
			if (flows[k].n != 4'h0)
				chk("cycles", {28'h0, flows[k].n}, n);
			chk("pc out", {10'h0, flows[k].pc}, {10'h0, prog_addr});
			rdchk("pc", 8'h34, {10'h0, flows[k].pc});
			rdchk("rpc", 8'h38, {10'h0, flows[k].return_address_reg});
			rdchk("sp", 8'h2C, {16'h0, flows[k].sp});
		end
		irq_in <= 16'h8001;
		@(posedge clock);
		irq_in <= 16'h0;
		repeat (3) @(posedge clock);
		chk("int", 32'h1F, {27'h0, int_out});
		rdchk("flags", 8'h44, 32'h8001);
		dbg_halt <= 1'h1;
		repeat (3) @(posedge clock);
		chk("halt", 32'h0, {31'h0, int_out.valid});
		bus(1'h1, 8'h40, 32'h8000, 4'hF);
		repeat (2) @(posedge clock);
		chk("dbg", 32'h1, {31'h0, int_out.valid});
		// Status: halted, interrupt pending, flow engine idle
		rdchk("stat", 8'h4C, 32'h6);
		dbg_halt <= 1'h0;
		bus(1'h1, 8'h44, 32'h1, 4'h3);
		rdchk("w1c", 8'h44, 32'h8000);
		int_ack <= '{1'h1, 4'hF};
		@(posedge clock);
		int_ack <= '0;
		repeat (3) @(posedge clock);
		chk("ack", 32'h0, {31'h0, int_out.valid});
		rdchk("ack flags", 8'h44, 32'h0);
		// Second reset in mid-run restores the stack pointer
		rst <= 1'h1;
		repeat (2) @(posedge clock);
		rst <= 1'h0;
		@(posedge clock);
		rdchk("sp rst", 8'h2C, 32'h0400);
		rdchk("rpc rst", 8'h38, 32'h0);
		end_of_test();
	end
endmodule : dspr_cpu_register_set_tb_top

/* File: verification/dspr_mem_model.sv */
`timescale 1ns/1ns
module dspr_mem_model (
	input wire logic clock,
	input wire logic [3:0] slow,
	input wire dspr_pkg::dspr_mreq_t dw_bus,
	output logic dw_ready,
	input wire dspr_pkg::dspr_mreq_t dr_bus,
	output logic dr_valid,
	output logic [31:0] dr_data
);
	import dspr_pkg::*;
	logic [31:0] mem [0:255];
	logic [3:0] wait_r;
	initial begin
		foreach (mem[i])
			mem[i] = '0;
		{dw_ready, dr_valid, dr_data, wait_r} = '0;
	end
	// Stall slow cycles, then answer one cycle; idle read data keeps moving
	always @(posedge clock) begin
		dw_ready <= 1'h0;
		dr_valid <= 1'h0;
		dr_data <= ~dr_data;
		if ((dw_bus.req && !dw_ready) || (dr_bus.req && !dr_valid)) begin
			wait_r <= wait_r + 4'h1;
			if (wait_r >= slow) begin
				wait_r <= 4'h0;
				if (dw_bus.req) begin
					mem[dw_bus.addr[7:0]] <= dw_bus.data;
					dw_ready <= 1'h1;
				end else begin
					dr_valid <= 1'h1;
					dr_data <= mem[dr_bus.addr[7:0]];
				end
			end
		end
	end
endmodule : dspr_mem_model

/* File: verilog/dspr_core_regs.sv */
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module dspr_core_regs (
	input wire logic clock,
	input wire logic rst,
	input wire logic [dspr_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire dspr_pkg::dspr_wr_t core_wr,
	input wire logic [dspr_pkg::IDX_W-1:0] core_rd_sel,
	output logic [31:0] core_rdata,
	input wire dspr_pkg::dspr_flow_t flow_in,
	output logic flow_ready,
	output logic flow_done,
	output logic [dspr_pkg::PC_W-1:0] prog_addr,
	output dspr_pkg::dspr_mreq_t dw_bus,
	input wire logic dw_ready,
	output dspr_pkg::dspr_mreq_t dr_bus,
	input wire logic dr_valid,
	input wire logic [31:0] dr_data,
	input wire logic [dspr_pkg::PAGE128_OFF_W-1:0] dir_off,
	output logic [31:0] dir_addr,
	input wire logic [dspr_pkg::IRQ_N-1:0] irq_in,
	input wire logic dbg_halt,
	input wire dspr_pkg::dspr_irq_t int_ack,
	output dspr_pkg::dspr_irq_t int_out
);
	import dspr_pkg::*;

	typedef enum logic [1:0] {
		FS_IDLE,
		FS_PUSH,
		FS_POP,
		FS_HOLD
	} dspr_fstate_t;

	dspr_fstate_t state_r;
	logic ack_r;
	logic [31:0] rdata_r;
	logic [31:0] core_rdata_r;
	logic [31:0] half_q [NUM_HALF_REGS];
	logic [PC_W-1:0] pc_r;
	logic [PC_W-1:0] rpc_r;
	logic [SP_W-1:0] sp_r;
	logic [DP_W-1:0] dp_r;
	logic [IRQ_N-1:0] ier_r;
	logic [IRQ_N-1:0] debug_interrupt_enable_reg_r;
	logic [IRQ_N-1:0] ifr_r;
	logic [IRQ_N-1:0] ifr_nxt;
	logic [IRQ_N-1:0] ifr_clr;
	logic [IRQ_N-1:0] elig;
	logic addressing_mode_select_r;
	logic [3:0] cnt_r;
	logic [3:0] lim_r;
	logic pop_to_pc_r;
	logic done_r;
	dspr_mreq_t dw_r;
	dspr_mreq_t dr_r;
	dspr_irq_t int_r;
	logic [31:0] dir_r;
	logic [IDX_W-1:0] bus_idx;
	logic bus_take;
	logic wr_v;
	logic [IDX_W-1:0] wr_sel;
	logic wr_lo;
	logic wr_hi;
	logic [31:0] wr_data;
	logic accept;
	logic push_done;
	logic pop_done;
	logic [3:0] pick;

	// Bus slave handshake: one wait cycle, and the bus yields to a core write
	// so that the two never land in the same register on the same edge
	assign bus_idx = avs_address[ADDR_W-1:2];
	assign avs_waitrequest = ~(ack_r & ~core_wr.valid);
	assign bus_take = avs_write & ~avs_waitrequest;
	assign avs_readdata = rdata_r;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read | avs_write) & ~(ack_r & ~core_wr.valid);
		end
	end

	// Merged write port: core first, bus otherwise; byte lanes pick halves
	always_comb begin
		if (core_wr.valid) begin
			wr_v = 1'b1;
			wr_sel = core_wr.sel;
			wr_lo = core_wr.lo;
			wr_hi = core_wr.hi;
			wr_data = core_wr.data;
		end else begin
			wr_v = bus_take;
			wr_sel = bus_idx;
			wr_lo = |avs_byteenable[1:0];
			wr_hi = |avs_byteenable[3:2];
			wr_data = avs_writedata;
		end
	end

	// Multiplicand, product, accumulator and the eight auxiliary pointers
	// share one split-half register shape
	for (genvar gi = 0; gi < NUM_HALF_REGS; gi++) begin : g_half
		dspr_half_reg u_reg (
			.clock(clock),
			.rst(rst),
			.we_lo(wr_v && wr_lo && (wr_sel == IDX_W'(gi))), // see [RULE1] see [RULE2]
			.we_hi(wr_v && wr_hi && (wr_sel == IDX_W'(gi))), // see [RULE3] see [RULE5]
			.d(wr_data),
			.q(half_q[gi])
		);
	end

	// Readback of every register; unmapped indices read as zero
	function automatic logic [31:0] rd_mux(input logic [IDX_W-1:0] idx);
		logic [31:0] v;
		v = WORD_RST;
		if (idx < IDX_SP) begin
			v = half_q[idx[3:0]]; // see [RULE6]
		end else begin
			case (idx)
				IDX_SP: v = {16'h0000, sp_r};
				IDX_DP: v = {16'h0000, dp_r}; // see [RULE16]
				IDX_PC: v = {10'h000, pc_r};
				IDX_RPC: v = {10'h000, rpc_r};
				IDX_IER: v = {16'h0000, ier_r};
				IDX_DEBUG_INTERRUPT_ENABLE_REG: v = {16'h0000, debug_interrupt_enable_reg_r};
				IDX_IFR: v = {16'h0000, ifr_r}; // see [RULE15]
				IDX_CTRL: v = {31'h0000_0000, addressing_mode_select_r};
				IDX_STAT: v = {29'h0000_0000, dbg_halt, int_r.valid, state_r != FS_IDLE};
				default: v = WORD_RST;
			endcase
		end
		return v;
	endfunction : rd_mux

	// Read data is captured in the wait cycle and stands while ack is high
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_r <= WORD_RST;
		end else if (avs_read && !ack_r) begin
			rdata_r <= rd_mux(bus_idx);
		end
	end

	// Core read port, one cycle behind its select
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			core_rdata_r <= WORD_RST;
		end else begin
			core_rdata_r <= rd_mux(core_rd_sel);
		end
	end
	assign core_rdata = core_rdata_r;

	// Plain control words: 16-bit page pointer and enables, one-bit mode select
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dp_r <= HALF_RST;
			ier_r <= HALF_RST;
			debug_interrupt_enable_reg_r <= HALF_RST;
			addressing_mode_select_r <= 1'b0;
		end else if (wr_v && wr_lo) begin
			case (wr_sel)
				IDX_DP: dp_r <= wr_data[15:0]; // see [RULE16]
				IDX_IER: ier_r <= wr_data[15:0];
				IDX_DEBUG_INTERRUPT_ENABLE_REG: debug_interrupt_enable_reg_r <= wr_data[15:0];
				IDX_CTRL: addressing_mode_select_r <= wr_data[CTRL_ADDRESSING_MODE_SELECT_BIT];
				default: ;
			endcase
		end
	end

	// Flow engine: accepted only when idle
	assign flow_ready = (state_r == FS_IDLE);
	assign accept = flow_ready && (flow_in.op != FLOW_NONE);
	assign push_done = (state_r == FS_PUSH) && dw_ready;
	assign pop_done = (state_r == FS_POP) && dr_valid;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r <= FS_IDLE;
			cnt_r <= 4'h0;
			lim_r <= 4'h0;
			pop_to_pc_r <= 1'b0;
			done_r <= 1'b0;
			dw_r <= '0;
			dr_r <= '0;
		end else begin
			done_r <= 1'b0;
			if (cnt_r != CNT_MAX) begin
				cnt_r <= cnt_r + 4'h1;
			end
			case (state_r)
				FS_IDLE: begin
					if (accept) begin
						cnt_r <= 4'h1;
						case (flow_in.op)
							FLOW_JUMP: begin
								done_r <= 1'b1;
							end
							FLOW_CALL: begin
								// Return address goes straight to the stack
								dw_r <= '{1'b1, {16'h0000, sp_r}, {10'h000, flow_in.ret}}; // see [RULE11]
								state_r <= FS_PUSH;
							end
							FLOW_CALL_RPC: begin
								// Old return register content is what gets pushed
								dw_r <= '{1'b1, {16'h0000, sp_r}, {10'h000, rpc_r}}; // see [RULE8]
								state_r <= FS_PUSH;
							end
							FLOW_RET: begin
								dr_r <= '{1'b1, {16'h0000, sp_r - STACK_WORDS}, WORD_RST}; // see [RULE11]
								pop_to_pc_r <= 1'b1;
								lim_r <= RET_STK_CYC; // see [RULE10]
								state_r <= FS_POP;
							end
							FLOW_RET_RPC: begin
								dr_r <= '{1'b1, {16'h0000, sp_r - STACK_WORDS}, WORD_RST}; // see [RULE9]
								pop_to_pc_r <= 1'b0;
								lim_r <= RET_RPC_CYC; // see [RULE10]
								state_r <= FS_POP;
							end
							default: ;
						endcase
					end
				end
				FS_PUSH: begin
					if (dw_ready) begin
						dw_r.req <= 1'b0;
						done_r <= 1'b1;
						state_r <= FS_IDLE;
					end
				end
				FS_POP: begin
					if (dr_valid) begin
						dr_r.req <= 1'b0;
						state_r <= FS_HOLD;
					end
				end
				FS_HOLD: begin
					// Done is registered, so it is raised one count early to show on the limit
					if (cnt_r >= lim_r - 4'h1) begin
						done_r <= 1'b1; // see [RULE10]
						state_r <= FS_IDLE;
					end
				end
				default: state_r <= FS_IDLE;
			endcase
		end
	end
	assign flow_done = done_r;
	assign dw_bus = dw_r;
	assign dr_bus = dr_r;

	// Program counter: only the flow engine moves it
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pc_r <= PC_RST;
		end else if (accept && (flow_in.op == FLOW_RET_RPC)) begin
			pc_r <= rpc_r; // see [RULE9]
		end else if (accept && (flow_in.op != FLOW_RET)) begin
			pc_r <= flow_in.target; // see [RULE7]
		end else if (pop_done && pop_to_pc_r) begin
			pc_r <= dr_data[PC_W-1:0];
		end
	end
	assign prog_addr = pc_r; // see [RULE17] see [RULE19]

	// Return register: ordinary calls and returns never touch it
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rpc_r <= PC_RST;
		end else if (accept && (flow_in.op == FLOW_CALL_RPC)) begin
			rpc_r <= flow_in.ret; // see [RULE8]
		end else if (pop_done && !pop_to_pc_r) begin
			rpc_r <= dr_data[PC_W-1:0]; // see [RULE9]
		end
	end

	// Stack pointer: stack traffic wins over a port write in the same cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sp_r <= SP_RST;
		end else if (push_done) begin
			sp_r <= sp_r + STACK_WORDS; // see [RULE22]
		end else if (pop_done) begin
			sp_r <= sp_r - STACK_WORDS; // see [RULE4] see [RULE22]
		end else if (wr_v && wr_lo && (wr_sel == IDX_SP)) begin
			sp_r <= wr_data[15:0];
		end
	end

	// Direct address: page size follows the mode select
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dir_r <= WORD_RST;
		end else if (addressing_mode_select_r) begin
			dir_r <= {10'h000, dp_r[15:1], dir_off}; // see [RULE21] see [RULE18]
		end else begin
			dir_r <= {10'h000, dp_r, dir_off[PAGE64_OFF_W-1:0]}; // see [RULE20]
		end
	end
	assign dir_addr = dir_r;

	// Flag clears: write one to clear, plus the acknowledged line
	always_comb begin
		ifr_clr = '0;
		if (wr_v && wr_lo && (wr_sel == IDX_IFR)) begin
			ifr_clr = wr_data[15:0];
		end
		if (int_ack.valid) begin
			ifr_clr = ifr_clr | (16'h0001 << int_ack.num);
		end
		// A request in the clearing cycle survives
		ifr_nxt = (ifr_r & ~ifr_clr) | irq_in; // see [RULE15]
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ifr_r <= HALF_RST;
		end else begin
			ifr_r <= ifr_nxt; // see [RULE13]
		end
	end

	// While halted only lines also enabled for debug may be taken
	assign elig = ifr_r & ier_r & (dbg_halt ? debug_interrupt_enable_reg_r : 16'hFFFF); // see [RULE12] see [RULE14]

	// Lowest line number has priority
	always_comb begin
		pick = 4'h0;
		for (int i = IRQ_N - 1; i >= 0; i--) begin
			if (elig[i]) begin
				pick = 4'(i);
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			int_r <= '0;
		end else begin
			int_r <= '{|elig, pick}; // see [RULE12]
		end
	end
	assign int_out = int_r;
endmodule : dspr_core_regs

/* File: verilog/dspr_half_reg.sv */
`timescale 1ns/1ns
module dspr_half_reg (
	input wire logic clock,
	input wire logic rst,
	input wire logic we_lo,
	input wire logic we_hi,
	input wire logic [31:0] d,
	output logic [31:0] q
);
	import dspr_pkg::*;
	// Low half, written alone leaves the high half alone
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q[15:0] <= HALF_RST;
		end else if (we_lo) begin
			q[15:0] <= d[15:0]; // see [RULE6]
		end
	end

	// High half, independent of the low half
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q[31:16] <= HALF_RST;
		end else if (we_hi) begin
			q[31:16] <= d[31:16];
		end
	end
endmodule : dspr_half_reg

/* File: verilog/dspr_pkg.sv */
// How it works
// [RULE1] Multiplicand is 32 bits, two halves
// [RULE2] Product halves written or read separately
// [RULE3] Accumulator whole or as 16-bit halves
// [RULE4] Dedicated stack pointer addresses the stack
// [RULE5] Eight auxiliary pointers, 32 bits each
// [RULE6] Low-half auxiliary access keeps upper half
// [RULE7] Program counter is 22 bits wide
// [RULE8] Special call saves return, pushes old
// [RULE9] Special return uses register, refills from stack
// [RULE10] Special return 4 cycles, stack return 8
// [RULE11] Ordinary call and return bypass register
// [RULE12] Each enable bit gates one interrupt line
// [RULE13] Sixteen interrupt lines, one bit each
// [RULE14] Debug enables select interrupts while halted
// [RULE15] Flag register holds pending requests, core register
// [RULE16] Page pointer is standalone 16-bit register
// [RULE17] Program address bus has 22 signals
// [RULE18] Data address path has 32 signals
// [RULE19] Separate program, data-read, data-write buses
// [RULE20] Mode clear: 64-word pages, full pointer
// [RULE21] Mode set: 128-word pages, pointer bit0 ignored
// [RULE22] Stack pointer steps by stored word count
package dspr_pkg;
	localparam int WORD_W = 32;
	localparam int HALF_W = 16;
	localparam int PC_W = 22;
	localparam int SP_W = 16;
	localparam int DP_W = 16;
	localparam int IRQ_N = 16;
	localparam int NUM_AUX = 8;
	localparam int NUM_HALF_REGS = 11;
	localparam int ADDR_W = 8;
	localparam int IDX_W = 6;
	// Register indices; the byte address is four times the index
	localparam logic [5:0] IDX_MULT = 6'h00;
	localparam logic [5:0] IDX_PROD = 6'h01;
	localparam logic [5:0] IDX_ACC = 6'h02;
	localparam logic [5:0] IDX_AUX0 = 6'h03;
	localparam logic [5:0] IDX_SP = 6'h0B;
	localparam logic [5:0] IDX_DP = 6'h0C;
	localparam logic [5:0] IDX_PC = 6'h0D;
	localparam logic [5:0] IDX_RPC = 6'h0E;
	localparam logic [5:0] IDX_IER = 6'h0F;
	localparam logic [5:0] IDX_DEBUG_INTERRUPT_ENABLE_REG = 6'h10;
	localparam logic [5:0] IDX_IFR = 6'h11;
	localparam logic [5:0] IDX_CTRL = 6'h12;
	localparam logic [5:0] IDX_STAT = 6'h13;
	// Field positions
	localparam int CTRL_ADDRESSING_MODE_SELECT_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_IRQ_BIT = 1;
	localparam int STAT_HALT_BIT = 2;
	localparam int PAGE64_OFF_W = 6;
	localparam int PAGE128_OFF_W = 7;
	// Reset values
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [15:0] HALF_RST = 16'h0000;
	localparam logic [21:0] PC_RST = 22'h00_0000;
	localparam logic [15:0] SP_RST = 16'h0400;
	// One stack entry is a 32-bit value, two 16-bit words
	localparam logic [15:0] STACK_WORDS = 16'h0002;
	// Return latencies in clock cycles
	localparam logic [3:0] RET_RPC_CYC = 4'h4;
	localparam logic [3:0] RET_STK_CYC = 4'h8;
	localparam logic [3:0] CNT_MAX = 4'hF;

	typedef enum logic [2:0] {
		FLOW_NONE,
		FLOW_JUMP,
		FLOW_CALL,
		FLOW_RET,
		FLOW_CALL_RPC,
		FLOW_RET_RPC
	} dspr_flow_op_t;

	typedef struct packed {
		logic valid;
		logic [5:0] sel;
		logic lo;
		logic hi;
		logic [31:0] data;
	} dspr_wr_t;

	typedef struct packed {
		dspr_flow_op_t op;
		logic [21:0] target;
		logic [21:0] ret;
	} dspr_flow_t;

	typedef struct packed {
		logic req;
		logic [31:0] addr;
		logic [31:0] data;
	} dspr_mreq_t;

	typedef struct packed {
		logic valid;
		logic [3:0] num;
	} dspr_irq_t;
endpackage : dspr_pkg
